// ### design/fcs_defines.vh
// constants for the flash charger switch control block
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH
// clock period in ns
`define FCS_CLK_PERIOD_NS 10
// maximum on-time and off-time guards in ns (plain defaults)
`define FCS_MAX_ON_NS 20000
`define FCS_MAX_OFF_NS 40000
// guard counts: longest times round down
`define FCS_MAX_ON_CYC (`FCS_MAX_ON_NS / `FCS_CLK_PERIOD_NS)
`define FCS_MAX_OFF_CYC (`FCS_MAX_OFF_NS / `FCS_CLK_PERIOD_NS)
`define FCS_CNT_W 16
// peak setting mode codes
`define FCS_PK_LOGIC_LOW 2'h0
`define FCS_PK_ANALOG 2'h1
`define FCS_PK_LOGIC_HIGH 2'h2
// phase state codes
`define FCS_ST_IDLE 2'h0
`define FCS_ST_ON 2'h1
`define FCS_ST_OFF 2'h2
`endif

// ### design/fcs_switch_control.v
// switch control logic of the flash capacitor charger and flash gate driver
`default_nettype none
`include "fcs_defines.vh"

module fcs_switch_control #(
   parameter MAX_ON_CYC  = `FCS_MAX_ON_CYC,
   parameter MAX_OFF_CYC = `FCS_MAX_OFF_CYC
) (
   // clock and reset
   input  wire       clk,
   input  wire       rst,
   // host lines
   input  wire       charge_enable_in,
   input  wire       flash_trigger_in,
   // comparator results
   input  wire       current_comparator,
   input  wire       zero_comparator,
   input  wire       full_comparator,
   input  wire       switch_overvoltage_fault,
   input  wire       over_temp_in,
   // peak setting level detectors
   input  wire       peak_logic_low_level,
   input  wire       peak_logic_high_level,
   // outputs
   output wire       primary_switch,
   output wire       flash_gate_out,
   output wire       charge_done_n_o,
   output wire       charge_done_n_oe_n,
   output wire [1:0] peak_mode,
   output wire       ov_latched
);

   // ----------------------------------------
   // guard limits
   // ----------------------------------------
   // both guards share one phase counter, since only one phase runs at a time
   // limits are cut to the counter width on purpose; longer guards need a wider counter
   localparam [`FCS_CNT_W-1:0] ON_LIM  = MAX_ON_CYC[`FCS_CNT_W-1:0];
   localparam [`FCS_CNT_W-1:0] OFF_LIM = MAX_OFF_CYC[`FCS_CNT_W-1:0];
   // the on guard only backs up the peak trip; a healthy primary never reaches it
   // the off guard restarts the switch when the zero trip never comes, e.g. at start-up
   // the counter free-runs in idle and may wrap there; every entry to on or off reloads it

   // ----------------------------------------
   // phase sequence
   // ----------------------------------------
   // idle: switch off, waiting for a rise of enable or for the die to cool
   // on:   switch conducting, ended by the peak trip, the on guard or overvoltage
   // off:  transformer emptying, ended by the zero trip, the off guard or a full charge
   // a full charge and an overvoltage trip both drop the enable latch, so only a
   // fresh rise of enable can leave idle afterwards
   // over-temperature keeps the latch, so cooling alone restarts the charge,
   // while enable falling during it clears the latch and the charge stays stopped

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg [1:0]            state_q, state_d;
   reg [`FCS_CNT_W-1:0] cnt_q, cnt_d;
   reg                  en_prev_q;
   reg                  latch_q, latch_d;   // charge enable latch
   reg                  done_q, done_d;
   reg                  ov_q, ov_d;
   reg                  sw_q;
   reg                  gate_q;
   reg [1:0]            pk_q;

   // rise detector; enable held high through reset counts as a rise after release
   wire en_rise = charge_enable_in & ~en_prev_q;
   // enable low kills switching in the same cycle it is seen
   wire run = latch_q & charge_enable_in & ~over_temp_in & ~ov_q;
   // priority below: enable low, then a new rise, then heat, then lost latch,
   // and only then the phase logic; a rise always wins over stale fault state

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always @* begin
      state_d = state_q;
      cnt_d   = cnt_q + {{(`FCS_CNT_W-1){1'b0}}, 1'b1};
      latch_d = latch_q;
      done_d  = done_q;
      ov_d    = ov_q;
      if (!charge_enable_in) begin
         latch_d = 1'b0;
         done_d  = 1'b0;
         ov_d    = 1'b0;
         state_d = `FCS_ST_IDLE;
      end else if (en_rise) begin
         latch_d = 1'b1;
         done_d  = 1'b0;
         ov_d    = 1'b0;
         state_d = `FCS_ST_ON;
         cnt_d   = {`FCS_CNT_W{1'b0}};
      end else if (over_temp_in) begin
         // latch kept, so charging resumes when the die cools
         state_d = `FCS_ST_IDLE;
      end else if (!run) begin
         state_d = `FCS_ST_IDLE;
      end else begin
         case (state_q)
            `FCS_ST_IDLE: begin
               // resume after over-temperature with enable held high
               state_d = `FCS_ST_ON;
               cnt_d   = {`FCS_CNT_W{1'b0}};
            end
            `FCS_ST_ON: begin
               // overvoltage beats the peak trip: a shorted primary must never
               // be retried, whereas a peak trip just ends a normal on-phase
               if (switch_overvoltage_fault) begin
                  ov_d    = 1'b1;
                  latch_d = 1'b0;
                  state_d = `FCS_ST_IDLE;
               end else if (current_comparator || cnt_q >= ON_LIM) begin
                  state_d = `FCS_ST_OFF;
                  cnt_d   = {`FCS_CNT_W{1'b0}};
               end
            end
            `FCS_ST_OFF: begin
               // full beats zero: once the target is reached no further pulse
               // may be started, even if the kickback dips in the same cycle
               if (full_comparator) begin
                  done_d  = 1'b1;
                  latch_d = 1'b0;
                  state_d = `FCS_ST_IDLE;
               end else if (zero_comparator || cnt_q >= OFF_LIM) begin
                  state_d = `FCS_ST_ON;
                  cnt_d   = {`FCS_CNT_W{1'b0}};
               end
            end
            default: state_d = `FCS_ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         state_q   <= `FCS_ST_IDLE;
         cnt_q     <= {`FCS_CNT_W{1'b0}};
         en_prev_q <= 1'b0;
         latch_q   <= 1'b0;
         done_q    <= 1'b0;
         ov_q      <= 1'b0;
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         en_prev_q <= charge_enable_in;
         latch_q   <= latch_d;
         done_q    <= done_d;
         ov_q      <= ov_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // registered outputs; the switch also drops combinationally on enable low
   // the switch register follows the next phase, so a trip turns it off one
   // edge after the comparator is seen, not two
   // peak mode is a reported classification only; the analog current setting
   // itself stays outside this block
   always @(posedge clk) begin
      if (rst) begin
         sw_q   <= 1'b0;
         gate_q <= 1'b0;
         pk_q   <= `FCS_PK_LOGIC_LOW;
      end else begin
         sw_q   <= (state_d == `FCS_ST_ON);
         // plain gate, no mask delay after enable falls
         gate_q <= flash_trigger_in & ~charge_enable_in;
         if (peak_logic_high_level)
            pk_q <= `FCS_PK_LOGIC_HIGH;
         else if (!peak_logic_low_level)
            pk_q <= `FCS_PK_LOGIC_LOW;
         else
            pk_q <= `FCS_PK_ANALOG;
      end
   end

   // open-drain done flag: data tied low, only the enable toggles the pin
   // heat and enable low bypass the register so the switch drops with no delay
   assign primary_switch     = sw_q & charge_enable_in & ~over_temp_in;
   assign flash_gate_out     = gate_q;
   assign charge_done_n_o    = 1'b0;
   assign charge_done_n_oe_n = ~done_q;
   assign peak_mode          = pk_q;
   assign ov_latched         = ov_q;

endmodule
`default_nettype wire

// ### sim/fcs_host_model.sv
// host controller model: charge enable and flash trigger lines
`default_nettype none
module fcs_host_model (
   output var logic charge_enable_in,
   output var logic flash_trigger_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {charge_enable_in, flash_trigger_in} = 2'h0;
   // caller sits at a falling edge; a low then high enable starts a charge
   task automatic drive(input logic en, trig);
      charge_enable_in = en;
      flash_trigger_in = trig;
   endtask
endmodule
`default_nettype wire

// ### sim/fcs_switch_control_checker.sv
// port assertions for the flash charger switch control
`default_nettype none
module fcs_switch_control_checker #(
   parameter int MAX_ON_CYC = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic charge_enable_in,
   input wire logic flash_trigger_in,
   input wire logic current_comparator,
   input wire logic full_comparator,
   input wire logic switch_overvoltage_fault,
   input wire logic over_temp_in,
   input wire logic primary_switch,
   input wire logic flash_gate_out,
   input wire logic charge_done_n_oe_n,
   input wire logic ov_latched
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] on_q;
   // on-time length; bound allows two cycles of detection latency
   always_ff @(posedge clk) on_q <= (rst || !primary_switch) ? 16'h0 : on_q + 16'h1;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_off;
      primary_switch ##1 !primary_switch;
   endsequence
   AST_PEAK: assert property (primary_switch && current_comparator |=> !primary_switch)
      else $error("switch on after peak trip");
   AST_FULL: assert property (s_off ##0 (full_comparator && charge_enable_in && !over_temp_in
      && !ov_latched) |=> !charge_done_n_oe_n && !primary_switch) else $error("full stop missed");
   AST_MAXON: assert property (on_q <= MAX_ON_CYC + 2)
      else $error("on phase too long");
   AST_HOT: assert property (over_temp_in |-> !primary_switch)
      else $error("switch on while hot");
   AST_OV: assert property (primary_switch && switch_overvoltage_fault |=> ov_latched
      && !primary_switch) else $error("overvoltage not latched");
   AST_RISE: assert property (!charge_enable_in ##1 charge_enable_in && !over_temp_in
      |=> primary_switch || !charge_enable_in || over_temp_in) else $error("no start on rise");
   AST_ENLOW: assert property (!charge_enable_in |-> !primary_switch)
      else $error("switch on with enable low");
   AST_GATE: assert property (1 |=> flash_gate_out == ($past(flash_trigger_in)
      && !$past(charge_enable_in))) else $error("flash gate wrong");
endmodule
bind fcs_switch_control fcs_switch_control_checker #(.MAX_ON_CYC(MAX_ON_CYC)) chk_u (.*);
`default_nettype wire

// ### sim/tb.sv
// self-checking bench for the flash charger switch control
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int ON = 8;
   localparam int OFF = 16;
   logic clk, rst;
   logic [4:0] cmp;
   logic [1:0] pk;
   wire logic charge_enable_in, flash_trigger_in, primary_switch, flash_gate_out;
   wire logic charge_done_n_o, charge_done_n_oe_n, ov_latched;
   wire logic [1:0] peak_mode;
   int error_cnt = 0;
   int n_tests = 0;
   fcs_host_model host_u (.*);
   fcs_switch_control #(.MAX_ON_CYC(ON), .MAX_OFF_CYC(OFF)) dut_u (.*, .current_comparator(cmp[0]),
      .zero_comparator(cmp[1]), .full_comparator(cmp[2]), .switch_overvoltage_fault(cmp[3]),
      .over_temp_in(cmp[4]), .peak_logic_low_level(pk[0]), .peak_logic_high_level(pk[1]));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [1:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // comparator inputs change only at falling edges
   task automatic go(input logic [4:0] v, input int n = 1);
      cmp = v;
      repeat (n) @(negedge clk);
   endtask
   task automatic start();
      host_u.drive(1'b0, 1'b0);
      go(5'h00);
      host_u.drive(1'b1, 1'b0);
      go(5'h00);
      chk("sw_rise", primary_switch, 1);
   endtask
   task automatic t_cycle();
      start();
      go(5'h01);
      chk("sw_peak", primary_switch, 0);
      go(5'h02);
      chk("sw_zero", primary_switch, 1);
      go(5'h01);
      go(5'h06);
      chk("done", charge_done_n_oe_n, 0);
      go(5'h02, 3);
      chk("sw_full", primary_switch, 0);
      host_u.drive(1'b1, 1'b1);
      go(5'h00, 2);
      chk("gate_en", flash_gate_out, 0);
      host_u.drive(1'b0, 1'b1);
      go(5'h00);
      chk("done_rel", charge_done_n_oe_n, 1);
      chk("gate_fire", flash_gate_out, 1);
   endtask
   task automatic t_lim();
      int c;
      start();
      for (c = 0; primary_switch === 1'b1 && c < 40; c++) go(5'h00);
      chk("on_len", c inside {[ON - 1:ON + 2]}, 1);
      for (c = 0; primary_switch === 1'b0 && c < 60; c++) go(5'h00);
      chk("off_len", c inside {[OFF - 1:OFF + 2]}, 1);
      go(5'h10, 3);
      chk("sw_hot", primary_switch, 0);
      go(5'h00, 2);
      chk("sw_cool", primary_switch, 1);
      host_u.drive(1'b0, 1'b0);
      #1 chk("sw_drop", primary_switch, 0);
   endtask
   task automatic t_ov();
      start();
      go(5'h09);
      chk("ov_set", ov_latched, 1);
      go(5'h02, OFF + 4);
      chk("ov_hold", primary_switch, 0);
      chk("ov_flag", charge_done_n_oe_n, 1);
      chk("done_drv", charge_done_n_o, 0);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      {rst, cmp, pk} = 8'h80;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 3; i++) begin
         pk = {i > 1, i > 0};
         go(5'h00, 2);
         chk("peak_mode", peak_mode, i[1:0]);
      end
      t_cycle();
      t_lim();
      t_ov();
      print_verdict();
   end
   // the tests need well under a thousand cycles
   initial begin
      #50us;
      error_cnt++;
      print_verdict();
   end
endmodule
`default_nettype wire
